// ---- rtl/qdc_defines.svh ----
// Constants for the quad converter serial command control
`ifndef QDC_DEFINES_SVH
`define QDC_DEFINES_SVH
`define QDC_FRAME_W   24
`define QDC_DATA_W    16
`define QDC_CHANS     4
`define QDC_PD_W      8
`define QDC_CMD_W     4
`define QDC_CMD_IDLE  4'h0
`define QDC_CMD_WRIN  4'h1
`define QDC_CMD_UPD   4'h2
`define QDC_CMD_WRUPD 4'h3
`define QDC_CMD_PWR   4'h4
`define QDC_CMD_MASK  4'h5
`define QDC_CMD_CHAIN 4'h8
`define QDC_CMD_RDBK  4'h9
`define QDC_CMD_CHNOP 4'hf
`define QDC_PD_NORMAL 2'h0
`define QDC_PD_1K     2'h1
`define QDC_PD_100K   2'h2
`define QDC_PD_TRI    2'h3
`define QDC_RB_PAD    4'h0
`define QDC_RB_HI     19
`define QDC_RB_LO     4
`define QDC_CHAIN_BIT 0
`define QDC_CHAIN_RST 1'b0
`define QDC_PD_RST    8'h00
`define QDC_MASK_RST  4'h0
`define QDC_DAC_RST   16'h0000
`define QDC_FRAME_RST 24'h000000
`define QDC_CHAN_RST  2'h0
`define QDC_PIN_RST   4'hf
`endif

// ---- rtl/qdc_pkg.sv ----
// Types shared by the quad converter serial command control
`include "qdc_defines.svh"
package qdc_pkg;
  typedef enum logic [`QDC_CMD_W-1:0] {
    QDC_IDLE  = `QDC_CMD_IDLE,
    QDC_WRIN  = `QDC_CMD_WRIN,
    QDC_UPD   = `QDC_CMD_UPD,
    QDC_WRUPD = `QDC_CMD_WRUPD,
    QDC_PWR   = `QDC_CMD_PWR,
    QDC_MASK  = `QDC_CMD_MASK,
    QDC_CHAIN = `QDC_CMD_CHAIN,
    QDC_RDBK  = `QDC_CMD_RDBK,
    QDC_CHNOP = `QDC_CMD_CHNOP
  } qdc_cmd_t;

  typedef enum logic [1:0] {
    QDC_PD_NORMAL = `QDC_PD_NORMAL,
    QDC_PD_1K     = `QDC_PD_1K,
    QDC_PD_100K   = `QDC_PD_100K,
    QDC_PD_TRI    = `QDC_PD_TRI
  } qdc_pd_t;

  typedef struct packed {
    qdc_pd_t pdChanD;
    qdc_pd_t pdChanC;
    qdc_pd_t pdChanB;
    qdc_pd_t pdChanA;
  } qdc_pd_sel_t;

  typedef struct packed {
    logic [`QDC_CMD_W-1:0]  cmd;
    logic [`QDC_CHANS-1:0]  addr;
    logic [`QDC_DATA_W-1:0] data;
  } qdc_frame_t;

  typedef logic [`QDC_CHANS-1:0][`QDC_DATA_W-1:0] qdc_bank_t;
endpackage

// ---- rtl/qdc_sync3.sv ----
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module qdc_sync3 #(
  parameter int             W   = 1,
  parameter logic [W-1:0]   RST = '0
) (
  input  wire logic         mclk,   // System clock
  input  wire logic         resetn, // Async reset, active low
  input  wire logic [W-1:0] din,    // Raw pin levels
  output logic      [W-1:0] dout    // Filtered levels
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] out_r;
  logic [W-1:0] out_nxt;
  logic [W-1:0] agree;

  // A change counts only once stages two and three agree
  always_comb begin
    agree   = ~(s2_r ^ s3_r);
    out_nxt = (agree & s3_r) | (~agree & out_r);
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s1_r  <= RST;
      s2_r  <= RST;
      s3_r  <= RST;
      out_r <= RST;
    end else begin
      s1_r  <= din;
      s2_r  <= s1_r;
      s3_r  <= s2_r;
      out_r <= out_nxt;
    end
  end

  assign dout = out_r;
endmodule // qdc_sync3

// ---- rtl/qdc_buf2.sv ----
// Two-entry valid/ready buffer
`timescale 1ns/100ps
module qdc_buf2 #(
  parameter int W = 8
) (
  input  wire logic         mclk,     // System clock
  input  wire logic         resetn,   // Async reset, active low
  input  wire logic         inValid,  // Word offered
  output logic              inReady,  // Room for a word
  input  wire logic [W-1:0] inData,   // Word in
  output logic              outValid, // Word available
  input  wire logic         outReady, // Drain side accepts
  output logic      [W-1:0] outData   // Word out
);
  logic [W-1:0] mem_r [2];
  logic [W-1:0] mem_nxt [2];
  logic         wrPtr_r;
  logic         wrPtr_nxt;
  logic         rdPtr_r;
  logic         rdPtr_nxt;
  logic [1:0]   cnt_r;
  logic [1:0]   cnt_nxt;
  logic         push;
  logic         pop;

  assign inReady  = (cnt_r != 2'h2);
  assign outValid = (cnt_r != 2'h0);
  assign outData  = mem_r[rdPtr_r];

  always_comb begin
    push      = inValid && inReady;
    pop       = outValid && outReady;
    mem_nxt   = mem_r;
    wrPtr_nxt = wrPtr_r;
    rdPtr_nxt = rdPtr_r;
    if (push) begin
      mem_nxt[wrPtr_r] = inData;
      wrPtr_nxt        = ~wrPtr_r;
    end
    if (pop) begin
      rdPtr_nxt = ~rdPtr_r;
    end
    cnt_nxt = cnt_r + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      mem_r[0] <= '0;
      mem_r[1] <= '0;
      wrPtr_r  <= 1'b0;
      rdPtr_r  <= 1'b0;
      cnt_r    <= 2'h0;
    end else begin
      mem_r    <= mem_nxt;
      wrPtr_r  <= wrPtr_nxt;
      rdPtr_r  <= rdPtr_nxt;
      cnt_r    <= cnt_nxt;
    end
  end
endmodule // qdc_buf2

// ---- rtl/qdc_serial_ctrl.sv ----
// Serial command and register control of a quad voltage-output converter
`timescale 1ns/100ps
`include "qdc_defines.svh"

// What this block and its host do
// [RULE1] 24-bit frames, MSB first, falling edges
// [RULE2] Write-and-update loads output register directly
// [RULE3] Command 1000 sets chain mode from DB0
// [RULE4] Bits past 24 clocks leave on serial_out
// [RULE5] Serial output changes on rising clock edges
// [RULE6] Host sends 24 times N clocks
// [RULE7] Short or long frames still execute
// [RULE8] Frame select rise latches, stops shifting
// [RULE9] Host gates clock burst exactly per frame
// [RULE10] Readback command selects one output register
// [RULE11] Output enabled during read, off afterwards
// [RULE12] Bad readback address returns channel A
// [RULE13] Next frame returns register in DB19..DB4
// [RULE14] Host sends no-operation frame to collect
// [RULE15] Command 0100 loads eight power-down bits
// [RULE16] Power-down code: normal, 1k, 100k, tristate
// [RULE17] Power-down keeps output register, accepts updates
// [RULE18] Input and output register per channel
// [RULE19] Strobe low: write updates both registers
// [RULE20] Strobe falling edge copies input to output
// [RULE21] Command 0101 loads strobe mask bits
// [RULE22] Reset: normal power, no readback pending
module qdc_serial_ctrl
  import qdc_pkg::*;
(
  input  wire logic  mclk,         // System clock, 250 MHz
  input  wire logic  resetn,       // Async reset, active low
  input  wire logic  sclk,         // Serial clock from host
  input  wire logic  frameSelN,    // Frame select, active low
  input  wire logic  serialIn,     // Serial data in
  input  wire logic  loadStrobeN,  // Load strobe, active low
  output logic       serialOut,    // Serial data out
  output logic       serialOutEn,  // Serial output driven
  output logic       chainEnable,  // Daisy-chain mode
  output qdc_pd_sel_t pdSel,       // Power-down codes per channel
  output logic [`QDC_CHANS-1:0] strobeMask, // Strobe mask per channel
  output qdc_bank_t  dacOut,       // Output registers
  output logic       frameBusy     // Command buffer full
);
  //----------------------------------------------------------------
  // Pin synchronisers and edge detection
  //----------------------------------------------------------------
  logic       sclkF;
  logic       selF;
  logic       sdiF;
  logic       strobeF;
  logic       sclkPrev_r;
  logic       selPrev_r;
  logic       strobePrev_r;
  logic       sclkFall;
  logic       sclkRise;
  logic       frameStart;
  logic       frameEnd;
  logic       frameLow;
  logic       strobeFall;

  qdc_sync3 #(
    .W   (4),
    .RST (`QDC_PIN_RST)
  ) u_sync (
    .mclk   (mclk),
    .resetn (resetn),
    .din    ({sclk, frameSelN, serialIn, loadStrobeN}),
    .dout   ({sclkF, selF, sdiF, strobeF})
  );

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sclkPrev_r   <= 1'b1;
      selPrev_r    <= 1'b1;
      strobePrev_r <= 1'b1;
    end else begin
      sclkPrev_r   <= sclkF;
      selPrev_r    <= selF;
      strobePrev_r <= strobeF;
    end
  end

  assign sclkFall   = sclkPrev_r && !sclkF;
  assign sclkRise   = !sclkPrev_r && sclkF;
  assign frameStart = selPrev_r && !selF;
  assign frameEnd   = !selPrev_r && selF;
  assign frameLow   = !selF;
  assign strobeFall = strobePrev_r && !strobeF;

  //----------------------------------------------------------------
  // Shift register and serial output
  //----------------------------------------------------------------
  logic [`QDC_FRAME_W-1:0] sr_r;
  logic [`QDC_FRAME_W-1:0] sr_nxt;
  logic                    serOut_r;
  logic                    serOut_nxt;
  logic                    rdAct_r;
  logic                    rdAct_nxt;
  logic                    rbPend_r;
  logic                    rbPend_nxt;
  logic [1:0]              rbChan_r;
  logic [1:0]              rbChan_nxt;
  qdc_bank_t               dac_r;
  qdc_bank_t               dac_nxt;

  always_comb begin
    sr_nxt     = sr_r;
    serOut_nxt = serOut_r;
    rdAct_nxt  = rdAct_r;
    if (frameStart) begin
      if (rbPend_r) begin
        // [RULE13] Readback word load
        sr_nxt    = {`QDC_RB_PAD, dac_r[rbChan_r], `QDC_RB_PAD};
        rdAct_nxt = 1'b1;
      end
      // First bit is presented before any clock edge
      serOut_nxt = sr_nxt[`QDC_FRAME_W-1];
    end
    // [RULE1] Shift on falling edge
    if (frameLow && sclkFall) sr_nxt = {sr_r[`QDC_FRAME_W-2:0], sdiF};
    // [RULE4] [RULE5] Top bit out on rise
    if (frameLow && sclkRise) serOut_nxt = sr_r[`QDC_FRAME_W-1];
    // [RULE11] Read ends with frame
    if (frameEnd) rdAct_nxt = 1'b0;
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sr_r     <= `QDC_FRAME_RST;
      serOut_r <= 1'b0;
      rdAct_r  <= 1'b0;
    end else begin
      sr_r     <= sr_nxt;
      serOut_r <= serOut_nxt;
      rdAct_r  <= rdAct_nxt;
    end
  end

  //----------------------------------------------------------------
  // Command buffer
  //----------------------------------------------------------------
  // Decoupling lets a strobe update take priority without losing a frame
  logic       bufInReady;
  logic       bufOutValid;
  logic       bufOutReady;
  qdc_frame_t bufOut;
  logic       strobeUpd;
  logic       exec;

  // [RULE7] [RULE8] Every frame end executes
  qdc_buf2 #(
    .W (`QDC_FRAME_W)
  ) u_buf (
    .mclk     (mclk),
    .resetn   (resetn),
    .inValid  (frameEnd),
    .inReady  (bufInReady),
    .inData   (sr_r),
    .outValid (bufOutValid),
    .outReady (bufOutReady),
    .outData  (bufOut)
  );

  // [RULE20] Strobe only after frame select high
  assign strobeUpd   = strobeFall && selF;
  assign bufOutReady = !strobeUpd;
  assign exec        = bufOutValid && bufOutReady;

  //----------------------------------------------------------------
  // Register bank and command execution
  //----------------------------------------------------------------
  qdc_bank_t             in_r;
  qdc_bank_t             in_nxt;
  qdc_pd_sel_t           pd_r;
  qdc_pd_sel_t           pd_nxt;
  logic [`QDC_CHANS-1:0] mask_r;
  logic [`QDC_CHANS-1:0] mask_nxt;
  logic                  chain_r;
  logic                  chain_nxt;

  always_comb begin
    in_nxt     = in_r;
    dac_nxt    = dac_r;
    pd_nxt     = pd_r;
    mask_nxt   = mask_r;
    chain_nxt  = chain_r;
    rbChan_nxt = rbChan_r;
    rbPend_nxt = rbPend_r;
    if (frameStart) rbPend_nxt = 1'b0;
    // [RULE20] [RULE21] Deferred update, masked
    if (strobeUpd) begin
      for (int i = 0; i < `QDC_CHANS; i++) begin
        if (!mask_r[i]) dac_nxt[i] = in_r[i];
      end
    end
    if (exec) begin
      case (bufOut.cmd)
        // [RULE18] [RULE19] Input write, transparent
        QDC_WRIN: begin
          for (int i = 0; i < `QDC_CHANS; i++) begin
            if (bufOut.addr[i]) begin
              in_nxt[i] = bufOut.data;
              if (!strobeF && !mask_r[i]) begin
                dac_nxt[i] = bufOut.data;
              end
            end
          end
        end
        QDC_UPD: begin
          for (int i = 0; i < `QDC_CHANS; i++) begin
            if (bufOut.addr[i]) dac_nxt[i] = in_r[i];
          end
        end
        // [RULE2] Write and update
        QDC_WRUPD: begin
          for (int i = 0; i < `QDC_CHANS; i++) begin
            if (bufOut.addr[i]) begin
              in_nxt[i]  = bufOut.data;
              dac_nxt[i] = bufOut.data;
            end
          end
        end
        // [RULE15] [RULE17] Power-down codes only
        QDC_PWR: pd_nxt = qdc_pd_sel_t'(bufOut.data[`QDC_PD_W-1:0]);
        // [RULE21] Load strobe mask
        QDC_MASK: mask_nxt = bufOut.data[`QDC_CHANS-1:0];
        // [RULE3] Chain mode select
        QDC_CHAIN: chain_nxt = bufOut.data[`QDC_CHAIN_BIT];
        // [RULE10] [RULE12] Readback channel select
        QDC_RDBK: begin
          rbPend_nxt = 1'b1;
          unique case (bufOut.addr)
            4'h2:    rbChan_nxt = 2'h1;
            4'h4:    rbChan_nxt = 2'h2;
            4'h8:    rbChan_nxt = 2'h3;
            default: rbChan_nxt = `QDC_CHAN_RST;
          endcase
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      in_r     <= {`QDC_CHANS{`QDC_DAC_RST}};
      dac_r    <= {`QDC_CHANS{`QDC_DAC_RST}};
      // [RULE22] Normal power, nothing pending
      pd_r     <= qdc_pd_sel_t'(`QDC_PD_RST);
      rbPend_r <= 1'b0;
      mask_r   <= `QDC_MASK_RST;
      chain_r  <= `QDC_CHAIN_RST;
      rbChan_r <= `QDC_CHAN_RST;
    end else begin
      in_r     <= in_nxt;
      dac_r    <= dac_nxt;
      pd_r     <= pd_nxt;
      rbPend_r <= rbPend_nxt;
      mask_r   <= mask_nxt;
      chain_r  <= chain_nxt;
      rbChan_r <= rbChan_nxt;
    end
  end

  //----------------------------------------------------------------
  // Outputs
  //----------------------------------------------------------------
  // [RULE11] [RULE16] Enable and codes
  assign serialOut   = serOut_r;
  assign serialOutEn = chain_r || rdAct_r;
  assign chainEnable = chain_r;
  assign pdSel       = pd_r;
  assign strobeMask  = mask_r;
  assign dacOut      = dac_r;
  assign frameBusy   = !bufInReady;

  //----------------------------------------------------------------
  // Assertions
  //----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  property p_wrupd;
    exec && bufOut.cmd == QDC_WRUPD && bufOut.addr[0] |=> dac_r[0] == $past(bufOut.data);
  endproperty
  a_wrupd: assert property (p_wrupd) else $error("write-update missed"); // [RULE2]
  property p_chain;
    exec && bufOut.cmd == QDC_CHAIN |=> chainEnable == $past(bufOut.data[`QDC_CHAIN_BIT]);
  endproperty
  a_chain: assert property (p_chain) else $error("chain mode wrong"); // [RULE3]
  property p_outRise;
    frameLow && sclkRise |=> serialOut == $past(sr_r[`QDC_FRAME_W-1]);
  endproperty
  a_outRise: assert property (p_outRise) else $error("serial out not top bit"); // [RULE4]
  property p_outOnlyRise;
    $changed(serialOut) |-> $past(sclkRise || frameStart);
  endproperty
  a_outOnlyRise: assert property (p_outOnlyRise) else $error("serial out moved off edge"); // [RULE5]
  property p_frameExec;
    frameEnd && bufInReady |=> bufOutValid;
  endproperty
  a_frameExec: assert property (p_frameExec) else $error("frame not queued"); // [RULE7]
  property p_latched;
    selF && $past(selF) |-> $stable(sr_r);
  endproperty
  a_latched: assert property (p_latched) else $error("shift outside frame"); // [RULE8]
  // Standalone output must drop again once the read frame closes
  property p_rdEn;
    frameEnd && !chainEnable |=> !serialOutEn;
  endproperty
  a_rdEn: assert property (p_rdEn) else $error("output left on after read"); // [RULE11]
  property p_rbDefault;
    exec && bufOut.cmd == QDC_RDBK && !$onehot(bufOut.addr) |=> rbChan_r == `QDC_CHAN_RST && rbPend_r;
  endproperty
  a_rbDefault: assert property (p_rbDefault) else $error("bad address not channel A"); // [RULE12]
  property p_rbWord;
    frameStart && rbPend_r |=> sr_r[`QDC_RB_HI:`QDC_RB_LO] == $past(dac_r[rbChan_r]) && rdAct_r;
  endproperty
  a_rbWord: assert property (p_rbWord) else $error("readback word wrong"); // [RULE13]
  property p_pwr;
    exec && bufOut.cmd == QDC_PWR |=> pdSel == $past(bufOut.data[`QDC_PD_W-1:0]) && $stable(dac_r);
  endproperty
  a_pwr: assert property (p_pwr) else $error("power-down load wrong"); // [RULE17]
  property p_strobe;
    strobeUpd && !mask_r[0] |=> dac_r[0] == $past(in_r[0]);
  endproperty
  a_strobe: assert property (p_strobe) else $error("strobe update missed"); // [RULE20]
  property p_mask;
    exec && bufOut.cmd == QDC_MASK |=> strobeMask == $past(bufOut.data[`QDC_CHANS-1:0]);
  endproperty
  a_mask: assert property (p_mask) else $error("mask load wrong"); // [RULE21]

  c_readback: cover property (frameStart && rbPend_r ##[1:1000] frameEnd);
  c_chainOn: cover property (exec && bufOut.cmd == QDC_CHAIN && bufOut.data[`QDC_CHAIN_BIT]);
  c_strobe: cover property (strobeUpd && mask_r != `QDC_MASK_RST);
endmodule // qdc_serial_ctrl

// ---- dv/qdc_host_model.sv ----
// Host-side serial master model for the quad converter serial control
`timescale 1ns/100ps
module qdc_host_model (
  output logic      sclk,        // Serial clock, idle high
  output logic      frameSelN,   // Frame select, active low
  output logic      serialIn,    // Serial data to device
  input  wire logic serialOut,   // Serial data from device
  input  wire logic serialOutEn  // Device drives serialOut
);
  localparam realtime HALF = 62.5;

  initial begin
    sclk      = 1'b1;
    frameSelN = 1'b1;
    serialIn  = 1'b0;
  end

  // ----------------------------------------
  // Frame transfer
  // ----------------------------------------
  // MSB-first gated burst
  task automatic xfer(input logic [47:0] bits, input int n, input bit sel,
                      output logic [47:0] got, output bit enAll);
    got       = '0;
    enAll     = 1'b1;
    frameSelN = ~sel;
    #(HALF);
    for (int i = n - 1; i >= 0; i--) begin
      serialIn = bits[i];
      #(HALF);
      sclk  = 1'b0;
      got   = {got[46:0], serialOut};
      enAll = enAll & (serialOutEn === 1'b1);
      #(HALF);
      sclk = 1'b1;
    end
    #(HALF);
    frameSelN = 1'b1;
    // Released line shows the inverse, so a stale bit never passes for data
    serialIn = ~serialIn;
    #100;
  endtask
endmodule // qdc_host_model

// ---- dv/qdc_serial_ctrl_test.sv ----
// Self-checking bench for the quad converter serial command control
`timescale 1ns/100ps
module qdc_serial_ctrl_test
  import qdc_pkg::*;
();
  logic        mclk, resetn, loadStrobeN, sclk, frameSelN, serialIn;
  logic        serialOut, serialOutEn, chainEnable, frameBusy;
  qdc_pd_sel_t pdSel;
  logic [3:0]  strobeMask;
  qdc_bank_t   dacOut;
  int          badCount, totalChecks;
  int          inReg[4], outReg[4], pdM, maskM, chainM, rbPend, rbChan;
  longint      sr;
  logic [47:0] got;
  bit          enAll;
  logic [15:0] d;
  logic [3:0]  rbAddr[7] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h0, 4'h3, 4'hf};

  qdc_serial_ctrl uut (
    .mclk(mclk), .resetn(resetn), .sclk(sclk), .frameSelN(frameSelN),
    .serialIn(serialIn), .loadStrobeN(loadStrobeN), .serialOut(serialOut),
    .serialOutEn(serialOutEn), .chainEnable(chainEnable), .pdSel(pdSel),
    .strobeMask(strobeMask), .dacOut(dacOut), .frameBusy(frameBusy)
  );

  qdc_host_model host (
    .sclk(sclk), .frameSelN(frameSelN), .serialIn(serialIn),
    .serialOut(serialOut), .serialOutEn(serialOutEn)
  );

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // ----------------------------------------
  // Checking and reference model
  // ----------------------------------------
  task automatic check(input logic [63:0] act, input logic [63:0] exp, input string what);
    totalChecks++;
    if (act !== exp) begin
      badCount++;
      $display("[FAIL] %0t %s: got %h want %h", $time, what, act, exp);
    end
  endtask

  task automatic cmpAll();
    for (int c = 0; c < 4; c++) check(dacOut[c], 64'(outReg[c][15:0]), "output reg");
    check(pdSel, 64'(pdM[7:0]), "power-down codes");
    check(strobeMask, 64'(maskM[3:0]), "strobe mask");
    check(chainEnable, 64'(chainM[0]), "chain mode");
    check(frameBusy, 64'h0, "buffer full");
    if (!rbPend) check(serialOutEn, 64'(chainM[0]), "output enable");
  endtask

  task automatic exec(input logic [23:0] w);
    for (int c = 0; c < 4; c++) begin
      if (w[16+c]) begin
        case (w[23:20])
          4'h1: begin
            inReg[c] = w[15:0];
            if (loadStrobeN === 1'b0 && !maskM[c]) outReg[c] = w[15:0];
          end
          4'h2: outReg[c] = inReg[c];
          4'h3: begin
            inReg[c]  = w[15:0];
            outReg[c] = w[15:0];
          end
          default: ;
        endcase
      end
    end
    case (w[23:20])
      4'h4: pdM = w[7:0];
      4'h5: maskM = w[3:0];
      4'h8: chainM = w[0];
      4'h9: begin
        rbPend = 1;
        rbChan = (w[19:16] == 4'h2) ? 1 : (w[19:16] == 4'h4) ? 2 : (w[19:16] == 4'h8) ? 3 : 0;
      end
      default: ;
    endcase
  endtask

  task automatic frame(input logic [47:0] bits, input int n, input bit sel = 1'b1);
    logic [95:0] cat;
    bit          wasRb;
    wasRb = rbPend && sel;
    // Pending readback replaces what leaves the shift path next
    if (wasRb) sr = longint'(outReg[rbChan][15:0]) << 4;
    // Wide enough that a 48-clock frame keeps every old bit
    cat = (96'(sr) << n) | 96'(bits);
    host.xfer(bits, n, sel, got, enAll);
    if (sel) begin
      if (chainM && !wasRb) check(got, 64'(cat >> 24), "chained shift out");
      if (wasRb) check(got[19:4], 64'(outReg[rbChan][15:0]), "readback data");
      if (wasRb) check(enAll, 64'h1, "readback enable");
      rbPend = 0;
      sr     = longint'(cat[23:0]);
      exec(sr[23:0]);
    end
    repeat (30) @(negedge mclk);
    cmpAll();
  endtask

  task automatic strobe(input bit low);
    @(negedge mclk);
    loadStrobeN = ~low;
    if (low) for (int c = 0; c < 4; c++) if (!maskM[c]) outReg[c] = inReg[c];
    repeat (20) @(negedge mclk);
    cmpAll();
  endtask

  task automatic tallyAndFinish();
    if (badCount == 0 && totalChecks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    badCount = 0; totalChecks = 0; resetn = 1'b0; loadStrobeN = 1'b1;
    sr = 0; pdM = 0; maskM = 0; chainM = 0; rbPend = 0; rbChan = 0;
    foreach (inReg[c]) begin
      inReg[c]  = 0;
      outReg[c] = 0;
    end
    d = 16'($urandom(58684));
    repeat (10) @(negedge mclk);
    resetn = 1'b1;
    repeat (10) @(negedge mclk);
    cmpAll();
    for (int c = 0; c < 4; c++) begin
      d = 16'($urandom);
      frame(48'({4'h3, 4'(1 << c), d}), 24);
    end
    frame(48'h3f_ffff, 24);
    d = 16'($urandom);
    frame(48'({4'h1, 4'h5, d}), 24);
    strobe(1);
    strobe(0);
    frame(48'({4'h1, 4'h2, ~d}), 24);
    frame(48'h22_0000, 24);
    frame(48'h50_0005, 24);
    strobe(1);
    d = 16'($urandom);
    frame(48'({4'h1, 4'hf, d}), 24);
    strobe(0);
    frame(48'({4'h1, 4'hf, ~d}), 24);
    strobe(1);
    strobe(0);
    frame(48'h50_0000, 24);
    frame(48'h40_001b, 24);
    frame(48'({4'h3, 4'h1, 16'($urandom)}), 24);
    frame(48'h40_0000, 24);
    foreach (rbAddr[i]) begin
      frame(48'({4'h9, rbAddr[i], 16'($urandom)}), 24);
      frame(48'h00_0000, 24);
    end
    frame(48'h80_0001, 24);
    frame({24'($urandom), 4'h3, 4'h2, 16'($urandom)}, 48);
    frame(48'h98_0000, 24);
    frame(48'hf0_0000, 24);
    frame(48'h80_0003, 24);
    frame(48'({4'h1, 16'($urandom)}), 20);
    frame(48'($urandom), 24, 1'b0);
    frame(48'h80_0000, 24);
    frame(48'h30_1234, 24);
    tallyAndFinish();
  end

  initial begin
    repeat (100000) @(posedge mclk);
    badCount++;
    $display("[FAIL] %0t run did not complete in time", $time);
    tallyAndFinish();
  end
endmodule // qdc_serial_ctrl_test
